// [mpb_dev_model.sv]
`timescale 1ns/1ps
// Four strobe-style devices sharing the external bus, with one byte store
module mpb_dev_model
	import mpb_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [mpb_pkg::MPB_DATA_W-1:0] boot_vec,
	input wire logic ack_mode,
	input wire logic [7:0] delay,
	input wire logic [mpb_pkg::MPB_DEV_NUM-1:0] select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [mpb_pkg::MPB_LOW_ADDR_W-1:0] address,
	input wire logic [mpb_pkg::MPB_DATA_W-1:0] data_o,
	input wire logic data_oe,
	output logic [mpb_pkg::MPB_DATA_W-1:0] data_i,
	output logic extend_or_done_n
);
	logic [7:0] mem_r [0:63];
	logic [7:0] cnt_r;
	logic [7:0] last_r;
	logic [5:0] idx;
	logic strobe;
	logic rd_drive;
	////////////////////////////////////////////////////////////////////////////
	// Word picked by the two-bit index of the asserted select and the low address nibble
	always_comb begin
		idx = {2'h0, address[3:0]};
		for (int i = 0; i < 4; i++) begin
			if (select_n[i] == 1'b0) begin
				idx = {i[1:0], address[3:0]};
			end
		end
	end
	// Released pins toggle so a stale value never looks valid
	assign strobe = !read_strobe_n || !write_strobe_n;
	assign rd_drive = !read_strobe_n && (select_n != 4'hf);
	assign data_i = rst ? boot_vec : (rd_drive ? mem_r[idx] : ~last_r);
	// Wait holds low for delay cycles; acknowledge goes low after delay cycles
	assign extend_or_done_n = ack_mode ? !(strobe && cnt_r >= delay)
		: !(strobe && cnt_r < delay);
	////////////////////////////////////////////////////////////////////////////
	// Strobe cycle counter and write capture
	always_ff @(posedge clk) begin
		cnt_r <= strobe ? cnt_r + 8'h01 : 8'h00;
		last_r <= data_i;
		if (!write_strobe_n && data_oe && select_n != 4'hf) begin
			mem_r[idx] <= data_o;
		end
	end
endmodule

// [mpb_ext_bus.sv]
`timescale 1ns/1ps
// External memory and peripheral bus port
module mpb_ext_bus
	import mpb_pkg::*;
#(
	parameter logic [mpb_pkg::MPB_CNT_W-1:0] SETUP_CYC = mpb_pkg::MPB_SETUP_DEF,
	parameter logic [mpb_pkg::MPB_CNT_W-1:0] STROBE_CYC = mpb_pkg::MPB_STROBE_DEF,
	parameter logic [mpb_pkg::MPB_CNT_W-1:0] HOLD_CYC = mpb_pkg::MPB_HOLD_DEF
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic REQ_WRITE,
	input wire logic [mpb_pkg::MPB_SEL_W-1:0] REQ_SEL,
	input wire logic [mpb_pkg::MPB_ADDR_W-1:0] REQ_ADDR,
	input wire logic [mpb_pkg::MPB_DATA_W-1:0] REQ_WDATA,
	output logic RSP_VALID,
	output logic [mpb_pkg::MPB_DATA_W-1:0] RSP_RDATA,
	input wire logic ACK_MODE,
	input wire logic UPPER_ALT_EN,
	output logic [mpb_pkg::MPB_UPPER_W-1:0] UPPER_ADDR,
	output logic UPPER_ADDR_OE,
	output logic [mpb_pkg::MPB_LOW_ADDR_W-1:0] EXT_ADDRESS,
	input wire logic [mpb_pkg::MPB_DATA_W-1:0] EXT_DATA_I,
	output logic [mpb_pkg::MPB_DATA_W-1:0] EXT_DATA_O,
	output logic EXT_DATA_OE,
	output logic [mpb_pkg::MPB_DEV_NUM-1:0] DEVICE_SELECT_N,
	output logic READ_STROBE_N,
	output logic WRITE_STROBE_N,
	output logic READ_NOT_WRITE,
	output logic XCVR_DIRECTION_N,
	output logic XCVR_ENABLE_N,
	input wire logic EXTEND_OR_DONE_N,
	output logic [mpb_pkg::MPB_DATA_W-1:0] BOOT_VECTOR
);
	import mpb_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// State
	mpb_state_e state_r;
	mpb_state_e state_nxt;
	logic [MPB_CNT_W-1:0] cnt_r;
	logic [MPB_CNT_W-1:0] cnt_nxt;
	logic wr_r;
	logic [MPB_SEL_W-1:0] sel_r;
	logic [MPB_ADDR_W-1:0] addr_r;
	logic [MPB_DATA_W-1:0] wdata_r;
	logic ready_r;
	logic rsp_valid_r;
	logic [MPB_DATA_W-1:0] rdata_r;
	logic [MPB_DATA_W-1:0] boot_r;
	logic [MPB_DEV_NUM-1:0] sel_n_r;
	logic rd_n_r;
	logic wr_n_r;
	logic rnw_r;
	logic dir_n_r;
	logic en_n_r;
	logic [MPB_DATA_W-1:0] dout_r;
	logic doe_r;
	logic [MPB_UPPER_W-1:0] upper_r;
	logic upper_oe_r;

	////////////////////////////////////////////////////////////////////////////
	// Request acceptance and transaction fields for the next cycle
	wire accept = REQ_VALID && ready_r && (state_r == MPB_IDLE);
	wire wr_nxt = accept ? REQ_WRITE : wr_r;
	wire [MPB_SEL_W-1:0] sel_nxt = accept ? REQ_SEL : sel_r;
	wire [MPB_ADDR_W-1:0] addr_nxt = accept ? REQ_ADDR : addr_r;
	wire [MPB_DATA_W-1:0] wdata_nxt = accept ? REQ_WDATA : wdata_r;
	wire active_nxt = (state_nxt != MPB_IDLE);
	wire strobe_nxt = (state_nxt == MPB_STROBE);
	wire [MPB_DEV_NUM-1:0] sel_hot_nxt;
	wire [MPB_DEV_NUM-1:0] sel_hot_r;

	// Phase end conditions
	wire setup_done = (cnt_r == SETUP_CYC - MPB_CNT_ONE);
	wire strobe_min = (cnt_r >= STROBE_CYC - MPB_CNT_ONE);
	wire hold_done = (cnt_r == HOLD_CYC - MPB_CNT_ONE);
	wire ext_asserted = (EXTEND_OR_DONE_N == MPB_ASSERT_N);
	wire wait_release = (ACK_MODE == MPB_MODE_WAIT) && !ext_asserted;
	wire ack_seen = (ACK_MODE == MPB_MODE_ACK) && ext_asserted;
	wire strobe_done = strobe_min && (wait_release || ack_seen);

	// Select decoders for the next and the current transaction
	mpb_onehot #(.N(MPB_DEV_NUM), .W(MPB_SEL_W)) u_sel_nxt (
		.idx(sel_nxt),
		.hot(sel_hot_nxt)
	);
	mpb_onehot #(.N(MPB_DEV_NUM), .W(MPB_SEL_W)) u_sel_cur (
		.idx(sel_r),
		.hot(sel_hot_r)
	);

	////////////////////////////////////////////////////////////////////////////
	// Phase sequencing
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			MPB_IDLE: begin
				if (accept) begin
					state_nxt = MPB_SETUP;
				end
			end
			MPB_SETUP: begin
				if (setup_done) begin
					state_nxt = MPB_STROBE;
				end
			end
			MPB_STROBE: begin
				if (strobe_done) begin
					state_nxt = MPB_HOLD;
				end
			end
			MPB_HOLD: begin
				if (hold_done) begin
					state_nxt = MPB_IDLE;
				end
			end
			default: begin
				state_nxt = MPB_IDLE;
			end
		endcase
	end

	// Phase counter restarts on each phase change and saturates on long waits
	assign cnt_nxt = (state_nxt != state_r) ? MPB_CNT_ZERO :
		(cnt_r == MPB_CNT_MAX) ? cnt_r : cnt_r + MPB_CNT_ONE;

	////////////////////////////////////////////////////////////////////////////
	// Pin values for the next cycle
	wire [MPB_DEV_NUM-1:0] sel_n_nxt = active_nxt ? ~sel_hot_nxt : MPB_SEL_NONE_N;
	wire rd_n_nxt = (strobe_nxt && !wr_nxt) ? MPB_ASSERT_N : MPB_DEASSERT_N;
	wire wr_n_nxt = (strobe_nxt && wr_nxt) ? MPB_ASSERT_N : MPB_DEASSERT_N;
	wire rnw_nxt = (active_nxt && wr_nxt) ? MPB_RW_WRITE : MPB_RW_READ;
	wire dir_sel = wr_nxt ? MPB_DIR_OUTWARD_N : MPB_DIR_INWARD_N;
	wire dir_n_nxt = active_nxt ? dir_sel : dir_n_r;
	wire en_n_nxt = active_nxt ? MPB_ASSERT_N : MPB_DEASSERT_N;
	wire doe_nxt = active_nxt && wr_nxt;
	wire [MPB_UPPER_W-1:0] upper_sel = addr_nxt[MPB_ADDR_W-1:MPB_LOW_ADDR_W];
	wire [MPB_UPPER_W-1:0] upper_nxt = UPPER_ALT_EN ? upper_sel : MPB_UPPER_RST;
	wire rsp_nxt = (state_r == MPB_HOLD) && hold_done;
	wire capture_rd = (state_r == MPB_STROBE) && strobe_done && !wr_r;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer registers
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state_r <= MPB_IDLE;
			cnt_r <= MPB_CNT_ZERO;
			ready_r <= 1'h0;
			rsp_valid_r <= 1'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			ready_r <= !active_nxt;
			rsp_valid_r <= rsp_nxt;
		end
	end

	// Latched transaction fields
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			wr_r <= 1'h0;
			sel_r <= '0;
			addr_r <= '0;
			wdata_r <= MPB_DATA_RST;
		end else begin
			wr_r <= wr_nxt;
			sel_r <= sel_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
		end
	end

	// Read data is taken on the last strobe cycle
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			rdata_r <= MPB_DATA_RST;
		end else if (capture_rd) begin
			rdata_r <= EXT_DATA_I;
		end
	end

	// Boot vector follows the data pins through reset; last sample holds
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			boot_r <= EXT_DATA_I;
		end
	end

	// Strobe and select pins
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			sel_n_r <= MPB_SEL_NONE_N;
			rd_n_r <= MPB_DEASSERT_N;
			wr_n_r <= MPB_DEASSERT_N;
			rnw_r <= MPB_RW_READ;
		end else begin
			sel_n_r <= sel_n_nxt;
			rd_n_r <= rd_n_nxt;
			wr_n_r <= wr_n_nxt;
			rnw_r <= rnw_nxt;
		end
	end

	// Transceiver, address and data pins
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			dir_n_r <= MPB_DIR_INWARD_N;
			en_n_r <= MPB_DEASSERT_N;
			doe_r <= 1'h0;
			dout_r <= MPB_DATA_RST;
			upper_r <= MPB_UPPER_RST;
			upper_oe_r <= 1'h0;
		end else begin
			dir_n_r <= dir_n_nxt;
			en_n_r <= en_n_nxt;
			doe_r <= doe_nxt;
			dout_r <= wdata_nxt;
			upper_r <= upper_nxt;
			upper_oe_r <= UPPER_ALT_EN;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output drive
	assign REQ_READY = ready_r;
	assign RSP_VALID = rsp_valid_r;
	assign RSP_RDATA = rdata_r;
	assign EXT_ADDRESS = addr_r[MPB_LOW_ADDR_W-1:0];
	assign UPPER_ADDR = upper_r;
	assign UPPER_ADDR_OE = upper_oe_r;
	assign EXT_DATA_O = dout_r;
	assign EXT_DATA_OE = doe_r;
	assign DEVICE_SELECT_N = sel_n_r;
	assign READ_STROBE_N = rd_n_r;
	assign WRITE_STROBE_N = wr_n_r;
	assign READ_NOT_WRITE = rnw_r;
	assign XCVR_DIRECTION_N = dir_n_r;
	assign XCVR_ENABLE_N = en_n_r;
	assign BOOT_VECTOR = boot_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	AST_ONE_SELECT: assert property (@(posedge CLOCK) disable iff (RST)
		($countones(~DEVICE_SELECT_N) <= 1))
		else $error("more than one device select asserted");

	AST_SELECT_MATCH: assert property (@(posedge CLOCK) disable iff (RST)
		(!READ_STROBE_N || !WRITE_STROBE_N) |-> (DEVICE_SELECT_N == ~sel_hot_r))
		else $error("strobe without the addressed select");

	AST_READ_STROBE: assert property (@(posedge CLOCK) disable iff (RST)
		!READ_STROBE_N |-> (READ_NOT_WRITE && !EXT_DATA_OE && WRITE_STROBE_N))
		else $error("read strobe with bus driven or write marked");

	AST_WRITE_STROBE: assert property (@(posedge CLOCK) disable iff (RST)
		!WRITE_STROBE_N |-> (!READ_NOT_WRITE && EXT_DATA_OE && !XCVR_ENABLE_N))
		else $error("write strobe without driven data");

	AST_NO_DRIVE_RESET: assert property (@(posedge CLOCK)
		RST |=> (!EXT_DATA_OE && XCVR_ENABLE_N))
		else $error("data bus driven during reset");

	AST_BOOT_LATCH: assert property (@(posedge CLOCK)
		$fell(RST) |-> (BOOT_VECTOR == $past(EXT_DATA_I)) ##1 $stable(BOOT_VECTOR))
		else $error("boot vector not taken at reset release");

	AST_DIR_STABLE: assert property (@(posedge CLOCK) disable iff (RST)
		(!XCVR_ENABLE_N && $past(!XCVR_ENABLE_N)) |-> $stable(XCVR_DIRECTION_N))
		else $error("direction changed while buffer enabled");

	AST_DIR_READ: assert property (@(posedge CLOCK) disable iff (RST)
		!XCVR_ENABLE_N |-> (XCVR_DIRECTION_N == (READ_NOT_WRITE ? MPB_DIR_INWARD_N :
		MPB_DIR_OUTWARD_N)))
		else $error("direction does not follow transfer type");

	AST_WAIT_EXTEND: assert property (@(posedge CLOCK) disable iff (RST)
		(state_r == MPB_STROBE && ACK_MODE == MPB_MODE_WAIT && ext_asserted)
		|=> (state_r == MPB_STROBE))
		else $error("wait did not extend the cycle");

	AST_ACK_WAIT: assert property (@(posedge CLOCK) disable iff (RST)
		(state_r == MPB_STROBE && ACK_MODE == MPB_MODE_ACK && !ext_asserted)
		|=> (state_r == MPB_STROBE))
		else $error("cycle ended without acknowledge");

	AST_UPPER_GATED: assert property (@(posedge CLOCK) disable iff (RST)
		$past(!UPPER_ALT_EN) |-> (!UPPER_ADDR_OE && UPPER_ADDR == MPB_UPPER_RST))
		else $error("upper address shown without alternate function");

	COV_READ: cover property (@(posedge CLOCK) disable iff (RST)
		$fell(READ_STROBE_N) ##[1:20] RSP_VALID);
	COV_WRITE: cover property (@(posedge CLOCK) disable iff (RST)
		$fell(WRITE_STROBE_N) ##[1:20] RSP_VALID);
	COV_WAIT: cover property (@(posedge CLOCK) disable iff (RST)
		(state_r == MPB_STROBE && strobe_min && ACK_MODE == MPB_MODE_WAIT && ext_asserted));
	COV_ACK: cover property (@(posedge CLOCK) disable iff (RST)
		(state_r == MPB_STROBE && ACK_MODE == MPB_MODE_ACK && ack_seen));
endmodule

// [mpb_ext_bus_bench.sv]
`timescale 1ns/1ps
// Self-checking bench for the external bus port
module mpb_ext_bus_bench;
	import mpb_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [1:0] req_sel = 2'h0;
	logic [25:0] req_addr = 26'h0000000;
	logic [7:0] req_wdata = 8'h00;
	logic ack_mode = 1'b0;
	logic alt = 1'b0;
	logic [7:0] boot = 8'h00;
	logic [7:0] delay = 8'h00;
	logic req_ready, rsp_valid, upper_oe, data_oe, rd_n, wr_n, rnw, dir_n, en_n, wt_n;
	logic [7:0] rdata, data_i, data_o, boot_vector;
	logic [3:0] upper, sel_n;
	logic [21:0] address;
	int n_mismatch = 0;
	int n_tests = 0;
	int cycles = 0;
	mpb_ext_bus u_mpb_ext_bus (.CLOCK(clock), .RST(rst), .REQ_VALID(req_valid),
		.REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_SEL(req_sel),
		.REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid),
		.RSP_RDATA(rdata), .ACK_MODE(ack_mode), .UPPER_ALT_EN(alt), .UPPER_ADDR(upper),
		.UPPER_ADDR_OE(upper_oe), .EXT_ADDRESS(address), .EXT_DATA_I(data_i),
		.EXT_DATA_O(data_o), .EXT_DATA_OE(data_oe), .DEVICE_SELECT_N(sel_n),
		.READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .READ_NOT_WRITE(rnw),
		.XCVR_DIRECTION_N(dir_n), .XCVR_ENABLE_N(en_n), .EXTEND_OR_DONE_N(wt_n),
		.BOOT_VECTOR(boot_vector));
	mpb_dev_model u_mpb_dev_model (.clk(clock), .rst(rst), .boot_vec(boot),
		.ack_mode(ack_mode), .delay(delay), .select_n(sel_n), .read_strobe_n(rd_n),
		.write_strobe_n(wr_n), .address(address), .data_o(data_o), .data_oe(data_oe),
		.data_i(data_i), .extend_or_done_n(wt_n));
	////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Shared compare, closing report
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task automatic print_verdict();
		$display("mismatches=%0d comparisons=%0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Cold reset with a boot vector on the data pins; idle levels checked
	task automatic t_reset(input logic [7:0] bv);
		@(negedge clock);
		rst = 1'b1;
		boot = bv;
		repeat (12) begin
			@(negedge clock);
			cmp({sel_n, rd_n, wr_n, rnw, en_n, data_oe, req_ready}, {4'hf, 6'b111100});
		end
		rst = 1'b0;
		boot = ~bv;
		repeat (2) @(negedge clock);
		cmp({boot_vector, req_ready}, {bv, 1'b1});
	endtask
	// One transfer; wd is write data or expected read data, d is device delay
	task automatic xfer(input logic wr, input logic [1:0] sel, input logic [25:0] addr,
		input logic [7:0] wd, input logic [7:0] d);
		int lat;
		int nstb;
		int guard;
		int want;
		lat = 1;
		nstb = 0;
		guard = 0;
		want = 3 + ((d + 1 > 2) ? d + 1 : 2);
		delay = d;
		req_valid = 1'b1;
		req_write = wr;
		req_sel = sel;
		req_addr = addr;
		req_wdata = wr ? wd : ~wd;
		while (req_ready !== 1'b1 && guard < 20) begin
			@(negedge clock);
			guard++;
		end
		@(negedge clock);
		req_valid = 1'b0;
		while (rsp_valid !== 1'b1 && lat < 300) begin
			cmp({sel_n, en_n, dir_n, rnw, data_oe}, {~(4'h1 << sel), 1'b0, wr, !wr, wr});
			cmp({address, upper, upper_oe}, {addr[21:0], alt ? addr[25:22] : 4'h0, alt});
			cmp(wr ? rd_n : wr_n, 1'b1);
			if (wr) begin
				cmp(data_o, wd);
			end
			nstb += wr ? !wr_n : !rd_n;
			@(negedge clock);
			lat++;
		end
		cmp(lat, want);
		cmp(nstb, want - 3);
		cmp({sel_n, en_n}, {4'hf, 1'b1});
		if (!wr) begin
			cmp(rdata, wd);
		end
	endtask
	// Back-to-back writes then reads on every device
	task automatic t_rw_all();
		for (int s = 0; s < 4; s++) begin
			xfer(1'b1, s[1:0], {4'h9, 18'h2a5a5, 2'h1, s[1:0]}, 8'hc0 + s[7:0], 8'h00);
		end
		for (int s = 0; s < 4; s++) begin
			xfer(1'b0, s[1:0], {4'h9, 18'h2a5a5, 2'h1, s[1:0]}, 8'hc0 + s[7:0], 8'h00);
		end
	endtask
	// Wait mode stretch with upper address pins on
	task automatic t_wait();
		ack_mode = 1'b0;
		alt = 1'b1;
		repeat (2) @(negedge clock);
		xfer(1'b1, 2'h2, 26'h35abcd7, 8'h5e, 8'h04);
		xfer(1'b0, 2'h2, 26'h35abcd7, 8'h5e, 8'h04);
		alt = 1'b0;
		repeat (2) @(negedge clock);
	endtask
	// Acknowledge mode: immediate, late and later acknowledges
	task automatic t_ack();
		ack_mode = 1'b1;
		repeat (2) @(negedge clock);
		xfer(1'b0, 2'h1, {4'h9, 18'h2a5a5, 4'h5}, 8'hc1, 8'h00);
		xfer(1'b1, 2'h3, 26'h1000003, 8'ha7, 8'h03);
		xfer(1'b0, 2'h3, 26'h1000003, 8'ha7, 8'h06);
		ack_mode = 1'b0;
		repeat (2) @(negedge clock);
	endtask
	// Mid-run cold reset, then a write and its read-back on device 0
	task automatic t_after_reset();
		t_reset(8'h3c);
		xfer(1'b1, 2'h0, 26'h0000002, 8'h81, 8'h00);
		xfer(1'b0, 2'h0, 26'h0000002, 8'h81, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		t_reset(8'ha5);
		t_rw_all();
		t_wait();
		t_ack();
		t_after_reset();
		print_verdict();
	end
endmodule

// [mpb_onehot.sv]
`timescale 1ns/1ps
// Index to one-hot decoder for the device selects
module mpb_onehot #(
	parameter int N = 4,
	parameter int W = 2
) (
	input wire logic [W-1:0] idx,
	output logic [N-1:0] hot
);
	genvar i;
	// One compare per output line
	generate
		for (i = 0; i < N; i++) begin : g_line
			assign hot[i] = (idx == W'(i));
		end
	endgenerate
endmodule

// [mpb_pkg.sv]
// Functional notes
// - Separate 8-bit data and 26-bit address paths, no multiplexing.
// - Supplies every strobe for four devices, in both strobe conventions.
// - Four active-low selects; only the addressed one is asserted.
// - A 22-bit address output is driven for every transaction.
// - Address bits 25..22 appear only when the alternate function is on.
// - Data pins are inputs during cold reset and carry the boot vector.
// - Active-low transceiver direction output steers the external buffer.
// - Active-low transceiver enable is asserted for the whole bus cycle, setup through hold.
// - Active-low write strobe is asserted during writes.
// - Names ending in _N are asserted low; all others are asserted high.
// - Active-low read strobe is asserted while the device drives data.
// - Read/write indicator is high for reads and low for writes.
// - In wait mode an asserted wait input stretches the bus cycle.
// - In acknowledge mode the cycle ends only after the acknowledge.
package mpb_pkg;
	////////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int MPB_DATA_W = 8;
	localparam int MPB_ADDR_W = 26;
	localparam int MPB_LOW_ADDR_W = 22;
	localparam int MPB_UPPER_W = 4;
	localparam int MPB_DEV_NUM = 4;
	localparam int MPB_SEL_W = 2;
	localparam int MPB_CNT_W = 8;
	////////////////////////////////////////////////////////////////////////////
	// Default phase lengths in cycles, each at least one
	localparam logic [MPB_CNT_W-1:0] MPB_SETUP_DEF = 8'h01;
	localparam logic [MPB_CNT_W-1:0] MPB_STROBE_DEF = 8'h02;
	localparam logic [MPB_CNT_W-1:0] MPB_HOLD_DEF = 8'h01;
	localparam logic [MPB_CNT_W-1:0] MPB_CNT_ZERO = 8'h00;
	localparam logic [MPB_CNT_W-1:0] MPB_CNT_ONE = 8'h01;
	localparam logic [MPB_CNT_W-1:0] MPB_CNT_MAX = 8'hff;
	////////////////////////////////////////////////////////////////////////////
	// Pin levels
	localparam logic MPB_ASSERT_N = 1'h0;
	localparam logic MPB_DEASSERT_N = 1'h1;
	localparam logic MPB_RW_READ = 1'h1;
	localparam logic MPB_RW_WRITE = 1'h0;
	localparam logic MPB_DIR_INWARD_N = 1'h0;
	localparam logic MPB_DIR_OUTWARD_N = 1'h1;
	localparam logic MPB_MODE_WAIT = 1'h0;
	localparam logic MPB_MODE_ACK = 1'h1;
	localparam logic [MPB_DATA_W-1:0] MPB_DATA_RST = 8'h00;
	localparam logic [MPB_LOW_ADDR_W-1:0] MPB_ADDR_RST = 22'h000000;
	localparam logic [MPB_UPPER_W-1:0] MPB_UPPER_RST = 4'h0;
	localparam logic [MPB_DEV_NUM-1:0] MPB_SEL_NONE_N = 4'hf;
	////////////////////////////////////////////////////////////////////////////
	// Bus cycle phases
	typedef enum logic [3:0] {
		MPB_IDLE = 4'b0001,
		MPB_SETUP = 4'b0010,
		MPB_STROBE = 4'b0100,
		MPB_HOLD = 4'b1000
	} mpb_state_e;
endpackage
